// *** dac_device_core.sv ***
// Device end: serial command decoder, channel registers and power state.
// Function
// - Shift only on rising clock while selected.
// - Frame is command, address, sixteen data.
// - Code MSB first, padding bits lead.
// - Execute last frame on select rising.
// - Write stores data; address F selects all.
// - Commands 0-3 write and update variants.
// - Update copies input to converter register.
// - Update powers channel back up.
// - Command 4 powers down, ignores data.
// - Power-down keeps register contents.
// - Power-up delay 5, 12 or 30 us.
// - Command F does nothing.
// - Host sends only defined codes.
// - Optional 32-bit frame with eight pads.
// - Output bit leaves 32 edges later, falling.
// - Host chains devices, farthest frame first.
// - Outputs zero-scale after power application.
// - Clear low resets everything after a two-stage sync.
// - Serial output always driven.
`timescale 1ns/1ps
module dac_device_core
    import octal_dac_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Supply level: high selects the 3 V bias restart time.
    input  wire logic        lowSupply,
    // Serial link.
    dac_serial_if.device     link,
    // Channel outputs.
    output logic [CODE_WIDTH-1:0] activeCode [CHANNEL_COUNT],
    output logic [CHANNEL_COUNT-1:0] poweredDown,
    output logic [CHANNEL_COUNT-1:0] settling
);
    logic [2:0] csnSync_q;
    logic [2:0] sckSync_q;
    logic [1:0] sdiSync_q;
    logic [1:0] clrSync_q;
    logic [1:0] lowSync_q;
    logic [SHIFT_WIDTH-1:0] shift_q;
    logic sdo_q;
    logic [CODE_WIDTH-1:0] input_q [CHANNEL_COUNT];
    logic [CODE_WIDTH-1:0] conv_q [CHANNEL_COUNT];
    logic [CHANNEL_COUNT-1:0] pd_q;
    logic [CHANNEL_COUNT-1:0] settle_q;
    logic [DELAY_WIDTH-1:0] delay_q [CHANNEL_COUNT];
    logic clrN;
    logic selected;
    logic sckRise;
    logic sckFall;
    logic load;
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [CODE_WIDTH-1:0] word;
    logic addrOk;
    logic doWrite;
    logic doUpdSel;
    logic doUpdAll;
    logic doDown;
    logic [DELAY_WIDTH-1:0] wakeCycles;

    // Link pins come from another domain; the third stage only feeds edge detection.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            csnSync_q <= 3'h7;
            sckSync_q <= 3'h0;
            sdiSync_q <= 2'h0;
            clrSync_q <= 2'h3;
            lowSync_q <= 2'h0;
        end else begin
            csnSync_q <= {csnSync_q[1:0], link.selectAndLoadN};
            sckSync_q <= {sckSync_q[1:0], link.serialClk};
            sdiSync_q <= {sdiSync_q[0], link.serialDataIn};
            clrSync_q <= {clrSync_q[0], link.asyncClearN};
            lowSync_q <= {lowSync_q[0], lowSupply};
        end
    end

    assign clrN     = clrSync_q[1];
    assign selected = !csnSync_q[1];
    assign sckRise  = sckSync_q[1] && !sckSync_q[2] && selected;
    assign sckFall  = !sckSync_q[1] && sckSync_q[2];
    assign load     = csnSync_q[1] && !csnSync_q[2];
    assign cmd      = shift_q[CMD_MSB:CMD_LSB];
    assign addr     = shift_q[ADDR_MSB:ADDR_LSB];
    assign word     = shift_q[CODE_WIDTH-1:0];
    assign addrOk   = addr <= ADDR_LAST || addr == ADDR_ALL;
    always_comb begin
        doWrite  = 1'b0;
        doUpdSel = 1'b0;
        doUpdAll = 1'b0;
        doDown   = 1'b0;
        if (load && addrOk) begin
            case (cmd)
                CMD_WRITE: begin
                    doWrite = 1'b1;
                end
                CMD_UPDATE: begin
                    doUpdSel = 1'b1;
                end
                CMD_WRITE_ALL: begin
                    doWrite  = 1'b1;
                    doUpdAll = 1'b1;
                end
                CMD_WRITE_UPD: begin
                    doWrite  = 1'b1;
                    doUpdSel = 1'b1;
                end
                CMD_POWER_DOWN: begin
                    doDown = 1'b1;
                end
                // No-op and reserved codes do nothing.
                default: begin
                    doDown = 1'b0;
                end
            endcase
        end
    end
    // Bias restart when all eight down.
    assign wakeCycles = (&pd_q) ? DELAY_WIDTH'(lowSync_q[1] ? BIAS3_CYC : BIAS5_CYC) : DELAY_WIDTH'(PWRUP_CYC);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= '0;
            sdo_q <= 1'b0;
        end else if (!clrN) begin
            shift_q <= '0;
            sdo_q <= 1'b0;
        end else begin
            if (sckRise) begin
                shift_q <= {shift_q[SHIFT_WIDTH-2:0], sdiSync_q[1]};
            end
            // Top bit leaves on falling edge.
            if (sckFall) begin
                sdo_q <= shift_q[SHIFT_WIDTH-1];
            end
        end
    end

    assign link.serialDataOut = sdo_q;

    // A 4 ns core clock sees clear with two cycles lag, well inside the 20 ns clear pulse.
    for (genvar ch = 0; ch < CHANNEL_COUNT; ch++) begin : g_chan
        logic                   hit;
        logic                   upd;
        logic [DELAY_WIDTH-1:0] delay_d;
        assign hit = addr == ADDR_ALL || addr == 4'(ch);
        assign upd = (doUpdSel && hit) || doUpdAll;

        // Wake delay loads for downed channels.
        always_comb begin
            delay_d = delay_q[ch];
            if (upd) begin
                delay_d = pd_q[ch] ? wakeCycles : '0;
            end else if (doDown && hit) begin
                delay_d = '0;
            end else if (delay_q[ch] != '0) begin
                delay_d = delay_q[ch] - DELAY_WIDTH'(1);
            end
        end

        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                input_q[ch] <= CODE_RESET;
            end else if (!clrN) begin
                input_q[ch] <= CODE_RESET;
            end else if (doWrite && hit) begin
                input_q[ch] <= word;
            end
        end

        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                conv_q[ch] <= CODE_RESET;
            end else if (!clrN) begin
                conv_q[ch] <= CODE_RESET;
            end else if (upd) begin
                conv_q[ch] <= (doWrite && hit) ? word : input_q[ch];
            end
        end

        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                pd_q[ch] <= 1'b0;
            end else if (!clrN) begin
                pd_q[ch] <= 1'b0;
            end else if (upd) begin
                pd_q[ch] <= 1'b0;
            end else if (doDown && hit) begin
                pd_q[ch] <= 1'b1;
            end
        end

        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                delay_q[ch]  <= '0;
                settle_q[ch] <= 1'b0;
            end else if (!clrN) begin
                delay_q[ch]  <= '0;
                settle_q[ch] <= 1'b0;
            end else begin
                delay_q[ch]  <= delay_d;
                settle_q[ch] <= delay_d != '0;
            end
        end

        assign activeCode[ch]  = conv_q[ch];
        assign poweredDown[ch] = pd_q[ch];
        // Settling comes from a flop, so the output never shows compare glitches.
        assign settling[ch]    = settle_q[ch];
    end
endmodule : dac_device_core

// *** dac_host_ctrl.sv ***
// Host end: AXI4-Lite commanded serial frame sender.
`timescale 1ns/1ps
module dac_host_ctrl
    import octal_dac_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // AXI4-Lite slave.
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Serial link.
    dac_serial_if.host       link
);
    logic [31:0] frame_q;
    logic        long_q;
    logic        clear_q;
    logic        busy_q;
    logic [31:0] shift_q;
    logic [5:0]  bitsLeft_q;
    logic [SCK_DIV_WIDTH-1:0] div_q;
    logic        sck_q;
    logic        csn_q;
    logic [31:0] echo_q;
    logic        sdoMeta_q;
    logic        sdoSync_q;
    logic        awHeld_q;
    logic        wHeld_q;
    logic [3:0]  awAddr_q;
    logic [31:0] wData_q;
    logic        start;
    logic        tick;

    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_bresp   = 2'h0;
    assign s_axi_rresp   = 2'h0;
    assign start = awHeld_q && wHeld_q && awAddr_q == REG_FRAME && !busy_q;
    assign tick  = div_q == SCK_DIV_WIDTH'(SCK_HALF_CYC - 1);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
            frame_q <= 32'h0;
            long_q <= 1'b0;
            clear_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
            end
            // A frame write stalls while a frame is still on the wire.
            if (awHeld_q && wHeld_q && (awAddr_q != REG_FRAME || !busy_q)) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddr_q == REG_FRAME) begin
                    frame_q <= wData_q;
                end else if (awAddr_q == REG_CTRL) begin
                    long_q <= wData_q[0];
                    clear_q <= wData_q[1];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                REG_FRAME:  s_axi_rdata <= frame_q;
                REG_CTRL:   s_axi_rdata <= {30'h0, clear_q, long_q};
                REG_STATUS: s_axi_rdata <= {31'h0, busy_q};
                REG_ECHO:   s_axi_rdata <= echo_q;
                default:    s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Select low, bits change on falling clock.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
            csn_q <= 1'b1;
            sck_q <= 1'b0;
            div_q <= '0;
            shift_q <= 32'h0;
            bitsLeft_q <= 6'h0;
        end else if (start) begin
            busy_q <= 1'b1;
            csn_q <= 1'b0;
            sck_q <= 1'b0;
            div_q <= '0;
            // Long frame sends all 32 written bits; short sends the low 24 first.
            shift_q <= long_q ? wData_q : {wData_q[23:0], 8'h00};
            bitsLeft_q <= long_q ? 6'(LONG_BITS) : 6'(FRAME_BITS);
        end else if (busy_q) begin
            div_q <= tick ? '0 : div_q + SCK_DIV_WIDTH'(1);
            if (tick) begin
                if (bitsLeft_q == 6'h0) begin
                    csn_q <= 1'b1;
                    busy_q <= 1'b0;
                end else if (!sck_q) begin
                    sck_q <= 1'b1;
                end else begin
                    sck_q <= 1'b0;
                    shift_q <= {shift_q[30:0], 1'b0};
                    bitsLeft_q <= bitsLeft_q - 6'h1;
                end
            end
        end
    end

    // Chained devices return earlier frames here, sampled on the host's rising edge.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sdoMeta_q <= 1'b0;
            sdoSync_q <= 1'b0;
            echo_q <= 32'h0;
        end else begin
            sdoMeta_q <= link.serialDataOut;
            sdoSync_q <= sdoMeta_q;
            if (busy_q && tick && !sck_q && bitsLeft_q != 6'h0) begin
                echo_q <= {echo_q[30:0], sdoSync_q};
            end
        end
    end

    assign link.selectAndLoadN = csn_q;
    assign link.serialClk      = sck_q;
    assign link.serialDataIn   = shift_q[31];
    assign link.asyncClearN    = !clear_q;
endmodule : dac_host_ctrl

// *** dac_link_checker.sv ***
// Concurrent checks on the serial link between host and converter ends.
`timescale 1ns/1ps
module dac_link_checker
    import octal_dac_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // Serial link.
    input wire logic selectAndLoadN,
    input wire logic serialClk,
    input wire logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic asyncClearN
);
    logic [5:0] bitCnt_q;
    logic       sckPrev_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Rising clock edges are counted per frame, so a short frame shows at load time.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sckPrev_q <= 1'b0;
            bitCnt_q  <= 6'h00;
        end else begin
            sckPrev_q <= serialClk;
            bitCnt_q  <= selectAndLoadN ? 6'h00 : bitCnt_q + {5'h00, serialClk & ~sckPrev_q};
        end
    end

    a_sck_only_selected: assert property (serialClk |-> !selectAndLoadN)
        else $error("serial clock high while deselected");
    a_select_setup_gap: assert property ($fell(selectAndLoadN) |-> !serialClk [*8])
        else $error("serial clock rose too soon after select");
    a_sdi_stable_rise: assert property ($rose(serialClk) |-> $stable(serialDataIn))
        else $error("data changed at clock rise");
    a_sck_high_time: assert property ($rose(serialClk) |-> serialClk [*8])
        else $error("serial clock high time short");
    a_frame_bit_count: assert property ($rose(selectAndLoadN) |-> bitCnt_q == 6'h18 || bitCnt_q == 6'h20)
        else $error("frame length not 24 or 32");
    a_sdo_change_low: assert property ($changed(serialDataOut) |-> !serialClk)
        else $error("serial out changed while clock high");
    a_load_pulse_width: assert property ($rose(selectAndLoadN) |-> selectAndLoadN [*3])
        else $error("load pulse too short");
    a_clear_pulse_width: assert property ($fell(asyncClearN) |-> !asyncClearN [*5])
        else $error("clear pulse too short");

    c_short_frame: cover property ($rose(selectAndLoadN) && bitCnt_q == 6'h18);
    c_long_frame: cover property ($rose(selectAndLoadN) && bitCnt_q == 6'h20);
    c_clear: cover property ($fell(asyncClearN));
endmodule : dac_link_checker

// *** dac_serial_if.sv ***
// Three-wire serial link plus clear and chain output between host and converter.
`timescale 1ns/1ps
interface dac_serial_if;
    logic selectAndLoadN;
    logic serialClk;
    logic serialDataIn;
    logic serialDataOut;
    logic asyncClearN;
    modport host (output selectAndLoadN, output serialClk, output serialDataIn, output asyncClearN,
                  input serialDataOut);
    modport device (input selectAndLoadN, input serialClk, input serialDataIn, input asyncClearN,
                    output serialDataOut);
endinterface : dac_serial_if

// *** octal_dac_pkg.sv ***
// Shared constants for the octal converter serial command link.
package octal_dac_pkg;
    localparam int unsigned CHANNEL_COUNT  = 8;
    localparam int unsigned CODE_WIDTH     = 16;
    localparam int unsigned SHIFT_WIDTH    = 32;
    localparam int unsigned FRAME_BITS     = 24;
    localparam int unsigned LONG_BITS      = 32;
    localparam int unsigned CMD_MSB        = 23;
    localparam int unsigned CMD_LSB        = 20;
    localparam int unsigned ADDR_MSB       = 19;
    localparam int unsigned ADDR_LSB       = 16;
    localparam logic [3:0]  CMD_WRITE      = 4'h0;
    localparam logic [3:0]  CMD_UPDATE     = 4'h1;
    localparam logic [3:0]  CMD_WRITE_ALL  = 4'h2;
    localparam logic [3:0]  CMD_WRITE_UPD  = 4'h3;
    localparam logic [3:0]  CMD_POWER_DOWN = 4'h4;
    localparam logic [3:0]  CMD_NOP        = 4'hF;
    localparam logic [3:0]  ADDR_ALL       = 4'hF;
    localparam logic [3:0]  ADDR_LAST      = 4'h7;
    localparam logic [15:0] CODE_RESET     = 16'h0000;
    localparam logic [7:0]  PD_RESET       = 8'hFF;
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned PWRUP_US       = 5;
    localparam int unsigned BIAS5_US       = 12;
    localparam int unsigned BIAS3_US       = 30;
    localparam int unsigned PWRUP_CYC      = PWRUP_US * CLK_MHZ;
    localparam int unsigned BIAS5_CYC      = BIAS5_US * CLK_MHZ;
    localparam int unsigned BIAS3_CYC      = BIAS3_US * CLK_MHZ;
    localparam int unsigned SCK_HALF_CYC   = 20;
    localparam int unsigned SCK_DIV_WIDTH  = 5;
    localparam int unsigned DELAY_WIDTH    = 14;
    localparam logic [3:0]  REG_FRAME      = 4'h0;
    localparam logic [3:0]  REG_CTRL       = 4'h4;
    localparam logic [3:0]  REG_STATUS     = 4'h8;
    localparam logic [3:0]  REG_ECHO       = 4'hC;
endpackage : octal_dac_pkg

// *** tb.sv ***
// Self-checking bench joining host and converter ends across the serial link.
`timescale 1ns/1ps
module tb
    import octal_dac_pkg::*;
;
    typedef struct {
        logic [31:0] frame;
        logic        lng;
        int          ch;
        logic [15:0] code;
        logic        pd;
    } row_s;

    logic                  core_clk;
    logic                  rst_b;
    logic [3:0]            awAddr;
    logic                  awValid;
    logic                  awReady;
    logic [31:0]           wData;
    logic [3:0]            wStrb;
    logic                  wValid;
    logic                  wReady;
    logic                  bValid;
    logic                  bReady;
    logic [3:0]            arAddr;
    logic                  arValid;
    logic                  arReady;
    logic [31:0]           rData;
    logic                  rValid;
    logic                  rReady;
    logic                  lowSupply;
    logic [CODE_WIDTH-1:0] activeCode [CHANNEL_COUNT];
    logic [CHANNEL_COUNT-1:0] poweredDown;
    logic [CHANNEL_COUNT-1:0] settling;
    logic [31:0]           v;
    int                    num_errors = 0;
    int                    checks = 0;
    row_s                  rows [7] = '{
        '{32'h00301234, 1'b0, 0, 16'h1234, 1'b0}, '{32'h00015678, 1'b0, 1, 16'h0000, 1'b0},
        '{32'h00110000, 1'b0, 1, 16'h5678, 1'b0}, '{32'hA5229ABC, 1'b1, 2, 16'h9ABC, 1'b0},
        '{32'h3C42FFFF, 1'b1, 2, 16'h9ABC, 1'b1}, '{32'h00F01111, 1'b0, 0, 16'h1234, 1'b0},
        '{32'h003F0042, 1'b0, 7, 16'h0042, 1'b0}};

    dac_serial_if dac_serial_if_i ();

    dac_host_ctrl dac_host_ctrl_i (.core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .link(dac_serial_if_i.host));

    dac_device_core dac_device_core_i (.core_clk(core_clk), .rst_b(rst_b), .lowSupply(lowSupply),
        .link(dac_serial_if_i.device), .activeCode(activeCode), .poweredDown(poweredDown), .settling(settling));

    dac_link_checker dac_link_checker_i (.core_clk(core_clk), .rst_b(rst_b),
        .selectAndLoadN(dac_serial_if_i.selectAndLoadN), .serialClk(dac_serial_if_i.serialClk),
        .serialDataIn(dac_serial_if_i.serialDataIn), .serialDataOut(dac_serial_if_i.serialDataOut),
        .asyncClearN(dac_serial_if_i.asyncClearN));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic end_sim;
        if (num_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    // Handshakes are judged just before the edge, so the edge and the bench see the same values.
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        logic awT, wT, bT;
        awAddr  <= a;
        wData   <= d;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        bT = 1'b0;
        while (!bT) begin
            @(negedge core_clk);
            awT = awValid && awReady;
            wT  = wValid && wReady;
            bT  = bValid === 1'b1;
            @(posedge core_clk);
            if (awT) awValid <= 1'b0;
            if (wT) wValid <= 1'b0;
        end
        bReady <= 1'b0;
        @(posedge core_clk);
    endtask : axw

    task automatic axr(input logic [3:0] a, output logic [31:0] d);
        logic aT, rT;
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        rT = 1'b0;
        while (!rT) begin
            @(negedge core_clk);
            aT = arValid && arReady;
            rT = rValid === 1'b1;
            d  = rData;
            @(posedge core_clk);
            if (aT) arValid <= 1'b0;
        end
        rReady <= 1'b0;
        @(posedge core_clk);
    endtask : axr

    task automatic send(input logic lng, input logic [31:0] frame);
        logic [31:0] st;
        axw(4'h4, {31'h0, lng});
        axw(4'h0, frame);
        st = 32'h1;
        while (st[0] !== 1'b0) axr(4'h8, st);
        repeat (6) @(posedge core_clk);
    endtask : send

    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        end_sim();
    end

    initial begin
        rst_b = 1'b0;
        {awValid, wValid, bReady, arValid, rReady, lowSupply} = 6'h00;
        {awAddr, arAddr} = 8'h00;
        wData = 32'h0;
        wStrb = 4'hF;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 8; i++) chk(activeCode[i] === CODE_RESET, "reset code");
        for (int i = 0; i < 7; i++) begin
            send(rows[i].lng, rows[i].frame);
            chk(activeCode[rows[i].ch] === rows[i].code, "channel code");
            chk(poweredDown[rows[i].ch] === rows[i].pd, "power state");
            if (i == 4) begin
                axr(4'hC, v);
                chk(v === rows[3].frame, "chain echo");
            end
        end
        // All eight down forces the long bias restart on the next update.
        send(1'b0, 32'h004F0000);
        chk(activeCode[0] === 16'h0042, "code kept");
        chk(poweredDown === 8'hFF, "all down");
        send(1'b0, 32'h00100000);
        chk(poweredDown[0] === 1'b0 && settling[0] === 1'b1, "wake start");
        repeat (PWRUP_CYC) @(posedge core_clk);
        chk(settling[0] === 1'b1, "bias wait");
        repeat (BIAS5_CYC) @(posedge core_clk);
        chk(settling[0] === 1'b0, "bias done");
        // Seven down: only the short wake delay applies.
        send(1'b0, 32'h00110000);
        chk(settling[1] === 1'b1, "short wake start");
        repeat (PWRUP_CYC) @(posedge core_clk);
        chk(settling[1] === 1'b0, "short wake done");
        // All down on the low supply gives the longest restart.
        send(1'b0, 32'h004F0000);
        lowSupply <= 1'b1;
        send(1'b0, 32'h00100000);
        repeat (BIAS5_CYC) @(posedge core_clk);
        chk(settling[0] === 1'b1, "low supply wait");
        repeat (BIAS3_CYC - BIAS5_CYC) @(posedge core_clk);
        chk(settling[0] === 1'b0, "low supply done");
        lowSupply <= 1'b0;
        axw(4'h4, 32'h2);
        repeat (10) @(posedge core_clk);
        axw(4'h4, 32'h0);
        for (int i = 0; i < 8; i++) chk(activeCode[i] === CODE_RESET, "clear code");
        // A second reset in mid-run returns every channel to zero-scale.
        send(1'b0, 32'h00330ABC);
        chk(activeCode[3] === 16'h0ABC, "code before reset");
        rst_b <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 8; i++) chk(activeCode[i] === CODE_RESET, "mid-run reset code");
        end_sim();
    end
endmodule : tb
